/* flmc_pkg.sv */
// Constants, types and tone arithmetic for the FSK line modem control block
// Operation
// - Eight carriers from 60 kHz to 132.5 kHz, exactly one in use.
// - Symbol rate of 600, 1200, 2400 or 4800 baud, one rate for both directions.
// - Shared host line carries receive interrupt, or raw modem receive in bypass.
// - In bypass, transmit, direction and detect go to host port pins, receive to the shared host line.
// - In full operation all modem signals go to the access controller only.
// - Deviation one: one at carrier minus baud/2, zero at carrier plus baud/2.
// - Deviation half: one at carrier minus baud/4, zero at carrier plus baud/4.
// - Two modem instances, so transmit and receive deviation are set independently.
// - Output-stage bit one drives the switched transistor stage.
// - Output-stage bit zero uses the direct resistor-array outputs.
// - Mode field selects manual or automatic carrier-detect threshold.
// - Manual mode: level below threshold means busy, above means free.
// - Read-errors bit loads counts into window; write-threshold bit loads manual threshold.
// - Automatic mode: hardware adjusts threshold from false and missed counts.
// - Decision runs every decision-period value times 2^16 clock cycles.
// - Each run polls counters; threshold changes only if one exceeds the limit.
// - In manual mode the counters clear once they have been read.
// - 24-bit values pass through three byte registers, highest holds most significant.
// - Three-bit field: 000 is 60 kHz up to 111, 132.5 kHz, the default.
// - Transmit and receive deviation bits: clear is one, set is half.
package flmc_pkg;
    localparam int          ADDR_W      = 18;
    localparam logic [15:0] IDX_CTRL    = 16'hFE10;
    localparam logic [15:0] IDX_TH2     = 16'hFE11;
    localparam logic [15:0] IDX_TH1     = 16'hFE12;
    localparam logic [15:0] IDX_TH0     = 16'hFE13;
    localparam logic [15:0] IDX_FREQ    = 16'hFE16;
    localparam logic [15:0] IDX_CONFIG  = 16'hFE17;
    localparam logic [15:0] IDX_MODE    = 16'hFE48;
    localparam logic [15:0] IDX_PERIOD  = 16'hFE49;
    localparam logic [15:0] IDX_ERRLIM  = 16'hFE4A;
    localparam logic [15:0] IDX_BAUD    = 16'hFE60;
    localparam logic [15:0] IDX_BYPASS  = 16'hFE61;
    localparam logic [15:0] IDX_STATUS  = 16'hFE62;
    localparam logic [2:0]  RST_FREQ    = 3'h7;
    localparam logic [7:0]  RST_CONFIG  = 8'h06;
    localparam logic [7:0]  RST_MODE    = 8'h01;
    localparam logic [7:0]  RST_PERIOD  = 8'h20;
    localparam logic [7:0]  RST_ERRLIM  = 8'h0F;
    localparam int          CFG_RECEIVE_DEVIATION_BIT  = 6;
    localparam int          CFG_TRANSMIT_DEVIATION_BIT  = 5;
    localparam int          CFG_HBRIDGE = 3;
    localparam int          CFG_TR      = 2;
    localparam int          CTL_RDERR   = 4;
    localparam int          CTL_RDATH   = 3;
    localparam int          CTL_RDMTH   = 2;
    localparam int          CTL_WRITE_THRESHOLD_BIT   = 1;
    localparam int          CTL_RDPEAK  = 0;
    localparam int          MODE_AUTO   = 0;
    localparam int          DECISION_SHIFT = 16;

    typedef enum logic [1:0] {
        BAUD_600  = 2'h0,
        BAUD_1200 = 2'h1,
        BAUD_2400 = 2'h2,
        BAUD_4800 = 2'h3
    } flmc_baud_t;

    localparam flmc_baud_t RST_BAUD = BAUD_2400;

    typedef enum logic [1:0] {
        ST_COUNT  = 2'h1,
        ST_DECIDE = 2'h2
    } flmc_state_t;

    typedef struct packed {
        logic [2:0] freq;
        flmc_baud_t baud;
        logic       transmit_deviation_bit;
        logic       receive_deviation_bit;
        logic       tr;
        logic       hbridge;
        logic       auto_mode;
        logic       bypass;
    } flmc_cfg_t;

    function automatic logic [17:0] carrier_hz(input logic [2:0] f);
        case (f)
            3'h0:    carrier_hz = 18'h0EA60;
            3'h1:    carrier_hz = 18'h101D0;
            3'h2:    carrier_hz = 18'h11940;
            3'h3:    carrier_hz = 18'h128E0;
            3'h4:    carrier_hz = 18'h14082;
            3'h5:    carrier_hz = 18'h14FF0;
            3'h6:    carrier_hz = 18'h1ADB0;
            default: carrier_hz = 18'h20594;
        endcase
    endfunction

    function automatic logic [17:0] baud_hz(input flmc_baud_t b);
        case (b)
            BAUD_600:  baud_hz = 18'h00258;
            BAUD_1200: baud_hz = 18'h004B0;
            BAUD_2400: baud_hz = 18'h00960;
            default:   baud_hz = 18'h012C0;
        endcase
    endfunction

    // Mark sits below the carrier, space above
    function automatic logic [17:0] tone_hz(input logic [17:0] car, input logic [17:0] bd,
                                            input logic half, input logic mark);
        logic [17:0] off;
        off = half ? (bd >> 2) : (bd >> 1);
        tone_hz = mark ? car - off : car + off;
    endfunction
endpackage

/* flmc_top.sv */
// FSK line modem control: APB registers, tone selection, routing, carrier detect
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module flmc_top #(
    parameter int          TICK_SHIFT   = flmc_pkg::DECISION_SHIFT,
    parameter logic [23:0] AUTO_TH_INIT = 24'h100000,
    parameter logic [23:0] TH_STEP      = 24'h000100
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [flmc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [23:0]                 rx_level,
    input  wire logic [23:0]                 peak_level,
    input  wire logic                        false_det,
    input  wire logic                        missed_det,
    input  wire logic                        success_det,
    input  wire logic                        modem_rx_pin,
    output logic                             modem_tx_data,
    output logic                             direction_select,
    input  wire logic                        mac_tx_data,
    input  wire logic                        mac_dir,
    input  wire logic                        mac_rx_irq,
    output logic                             mac_rx_data,
    output logic                             mac_carrier_detect,
    input  wire logic                        host_port_bit_one,
    input  wire logic                        host_port_bit_two,
    output logic                             host_port_bit_zero,
    output logic                             shared_host_input_line,
    output logic      [17:0]                 tx_tone_hz,
    output logic      [17:0]                 rx_mark_hz,
    output logic      [17:0]                 rx_space_hz,
    output logic                             transistor_stage_en,
    output logic                             resistor_array_en,
    output logic                             full_bridge_en,
    output logic                             carrier_detect
);
    localparam int CNT_W = TICK_SHIFT + 8;

    if (TICK_SHIFT < 1 || TICK_SHIFT > 20)
    begin : g_bad_shift
        $error("flmc_top: TICK_SHIFT out of range");
    end

    // Register state
    logic [2:0]             freq_q;
    logic [7:0]             config_q;
    logic [7:0]             mode_q;
    logic [7:0]             period_q;
    logic [7:0]             errlim_q;
    flmc_pkg::flmc_baud_t   baud_q;
    logic                   bypass_q;
    logic [23:0]            window_q;
    logic [23:0]            mth_q;
    logic [23:0]            ath_q;
    logic [7:0]             false_cnt_q;
    logic [7:0]             missed_cnt_q;
    logic [7:0]             success_cnt_q;
    logic [31:0]            prdata_q;
    logic                   slverr_q;
    logic                   cd_q;
    logic [17:0]            tx_tone_q;
    logic [17:0]            rx_mark_q;
    logic [17:0]            rx_space_q;
    logic [CNT_W-1:0]       tick_q;
    flmc_pkg::flmc_state_t  state_q;
    logic [1:0]             rx_sync_q;
    logic [1:0]             htx_sync_q;
    logic [1:0]             hdir_sync_q;
    flmc_pkg::flmc_cfg_t    cfg;

    // APB decode
    wire [15:0] idx     = paddr[flmc_pkg::ADDR_W-1:2];
    wire        setup   = psel && !penable;
    wire        wr      = psel && penable && pwrite;
    wire        hit_ctl = idx == flmc_pkg::IDX_CTRL;
    wire        hit_th2 = idx == flmc_pkg::IDX_TH2;
    wire        hit_th1 = idx == flmc_pkg::IDX_TH1;
    wire        hit_th0 = idx == flmc_pkg::IDX_TH0;
    wire        hit_frq = idx == flmc_pkg::IDX_FREQ;
    wire        hit_cfg = idx == flmc_pkg::IDX_CONFIG;
    wire        hit_mod = idx == flmc_pkg::IDX_MODE;
    wire        hit_per = idx == flmc_pkg::IDX_PERIOD;
    wire        hit_lim = idx == flmc_pkg::IDX_ERRLIM;
    wire        hit_bd  = idx == flmc_pkg::IDX_BAUD;
    wire        hit_byp = idx == flmc_pkg::IDX_BYPASS;
    wire        hit_st  = idx == flmc_pkg::IDX_STATUS;
    wire        mapped  = hit_ctl || hit_th2 || hit_th1 || hit_th0 || hit_frq || hit_cfg
                          || hit_mod || hit_per || hit_lim || hit_bd || hit_byp || hit_st;
    wire        wr_ok   = wr && mapped;

    // Action strobes of the control register; they act once and read back as zero
    wire        do_write_threshold_bit = wr_ok && hit_ctl && pwdata[flmc_pkg::CTL_WRITE_THRESHOLD_BIT];
    wire        do_rderr = wr_ok && hit_ctl && pwdata[flmc_pkg::CTL_RDERR];
    wire        do_rdath = wr_ok && hit_ctl && pwdata[flmc_pkg::CTL_RDATH];
    wire        do_rdmth = wr_ok && hit_ctl && pwdata[flmc_pkg::CTL_RDMTH];
    wire        do_rdpk  = wr_ok && hit_ctl && pwdata[flmc_pkg::CTL_RDPEAK];

    assign cfg.freq      = freq_q;
    assign cfg.baud      = baud_q;
    assign cfg.transmit_deviation_bit    = config_q[flmc_pkg::CFG_TRANSMIT_DEVIATION_BIT];
    assign cfg.receive_deviation_bit    = config_q[flmc_pkg::CFG_RECEIVE_DEVIATION_BIT];
    assign cfg.tr        = config_q[flmc_pkg::CFG_TR];
    assign cfg.hbridge   = config_q[flmc_pkg::CFG_HBRIDGE];
    assign cfg.auto_mode = mode_q[flmc_pkg::MODE_AUTO];
    assign cfg.bypass    = bypass_q;

    // Read mux, captured in the setup phase so prdata is a flop
    wire [7:0]  status_b = {5'h00, cfg.bypass, cfg.auto_mode, cd_q};
    wire [31:0] rd_mux   = hit_th2 ? {24'h000000, window_q[23:16]} :
                           hit_th1 ? {24'h000000, window_q[15:8]}  :
                           hit_th0 ? {24'h000000, window_q[7:0]}   :
                           hit_frq ? {29'h00000000, freq_q}        :
                           hit_cfg ? {24'h000000, config_q}        :
                           hit_mod ? {24'h000000, mode_q}          :
                           hit_per ? {24'h000000, period_q}        :
                           hit_lim ? {24'h000000, errlim_q}        :
                           hit_bd  ? {30'h00000000, baud_q}        :
                           hit_byp ? {31'h00000000, bypass_q}      :
                           hit_st  ? {24'h000000, status_b}        : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
            slverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            slverr_q <= !mapped;
        end
    end

    assign pready  = psel && penable;
    assign prdata  = prdata_q;
    assign pslverr = slverr_q;

    // Plain configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            freq_q   <= flmc_pkg::RST_FREQ;
            config_q <= flmc_pkg::RST_CONFIG;
            mode_q   <= flmc_pkg::RST_MODE;
            period_q <= flmc_pkg::RST_PERIOD;
            errlim_q <= flmc_pkg::RST_ERRLIM;
            baud_q   <= flmc_pkg::RST_BAUD;
            bypass_q <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (hit_frq)
                freq_q <= pwdata[2:0];
            else if (hit_cfg)
                config_q <= pwdata[7:0];
            else if (hit_mod)
                mode_q <= pwdata[7:0];
            else if (hit_per)
                period_q <= pwdata[7:0];
            else if (hit_lim)
                errlim_q <= pwdata[7:0];
            else if (hit_bd)
                baud_q <= flmc_pkg::flmc_baud_t'(pwdata[1:0]);
            else if (hit_byp)
                bypass_q <= pwdata[0];
        end
    end

    // Threshold window: byte writes, or loads from the control strobes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            window_q <= 24'h000000;
        else if (do_rderr)
            window_q <= {false_cnt_q, missed_cnt_q, success_cnt_q};
        else if (do_rdath)
            window_q <= ath_q;
        else if (do_rdmth)
            window_q <= mth_q;
        else if (do_rdpk)
            window_q <= peak_level;
        else if (wr_ok && hit_th2)
            window_q[23:16] <= pwdata[7:0];
        else if (wr_ok && hit_th1)
            window_q[15:8] <= pwdata[7:0];
        else if (wr_ok && hit_th0)
            window_q[7:0] <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mth_q <= 24'h000000;
        else if (do_write_threshold_bit)
            mth_q <= window_q;
    end

    // Detection counters saturate; an event in the clearing cycle survives
    wire decide   = state_q == flmc_pkg::ST_DECIDE;
    wire clr_cnt  = (do_rderr && !cfg.auto_mode) || (decide && cfg.auto_mode);

    function automatic logic [7:0] cnt_next(input logic [7:0] c, input logic clr,
                                            input logic ev);
        logic [7:0] base;
        base = clr ? 8'h00 : c;
        cnt_next = (ev && base != 8'hFF) ? base + 8'h01 : base;
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            false_cnt_q   <= 8'h00;
            missed_cnt_q  <= 8'h00;
            success_cnt_q <= 8'h00;
        end
        else
        begin
            false_cnt_q   <= cnt_next(false_cnt_q, clr_cnt, false_det);
            missed_cnt_q  <= cnt_next(missed_cnt_q, clr_cnt, missed_det);
            success_cnt_q <= cnt_next(success_cnt_q, clr_cnt, success_det);
        end
    end

    // Decision timer: period register times 2^TICK_SHIFT cycles; zero stops the decision runs
    wire [CNT_W-1:0] tick_end = {period_q, {TICK_SHIFT{1'b0}}};
    wire             tick_hit = cfg.auto_mode && period_q != 8'h00
                                && tick_q == tick_end - 1'b1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_q <= '0;
        else if (tick_hit || !cfg.auto_mode)
            tick_q <= '0;
        else
            tick_q <= tick_q + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= flmc_pkg::ST_COUNT;
        else
        begin
            case (state_q)
                flmc_pkg::ST_COUNT:
                    state_q <= tick_hit ? flmc_pkg::ST_DECIDE : flmc_pkg::ST_COUNT;
                default:
                    state_q <= flmc_pkg::ST_COUNT;
            endcase
        end
    end

    // Too many false hits: lower the threshold; too many misses: raise it
    wire too_false  = false_cnt_q > errlim_q;
    wire too_missed = missed_cnt_q > errlim_q;
    wire ath_dn_ok  = ath_q >= TH_STEP;
    wire ath_up_ok  = ath_q <= 24'hFFFFFF - TH_STEP;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ath_q <= AUTO_TH_INIT;
        else if (decide && cfg.auto_mode)
        begin
            if (too_false && !too_missed && ath_dn_ok)
                ath_q <= ath_q - TH_STEP;
            else if (too_missed && !too_false && ath_up_ok)
                ath_q <= ath_q + TH_STEP;
        end
    end

    // Level below threshold means carrier present
    wire [23:0] th_used = cfg.auto_mode ? ath_q : mth_q;
    wire        busy    = rx_level < th_used;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cd_q <= 1'b0;
        else
            cd_q <= busy;
    end

    // Two modem instances: transmit and receive deviation are independent
    wire [17:0] car_hz = flmc_pkg::carrier_hz(cfg.freq);
    wire [17:0] bd_hz  = flmc_pkg::baud_hz(cfg.baud);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_tone_q  <= 18'h00000;
            rx_mark_q  <= 18'h00000;
            rx_space_q <= 18'h00000;
        end
        else
        begin
            tx_tone_q  <= flmc_pkg::tone_hz(car_hz, bd_hz, cfg.transmit_deviation_bit, modem_tx_data);
            rx_mark_q  <= flmc_pkg::tone_hz(car_hz, bd_hz, cfg.receive_deviation_bit, 1'b1);
            rx_space_q <= flmc_pkg::tone_hz(car_hz, bd_hz, cfg.receive_deviation_bit, 1'b0);
        end
    end

    assign tx_tone_hz  = tx_tone_q;
    assign rx_mark_hz  = rx_mark_q;
    assign rx_space_hz = rx_space_q;

    assign transistor_stage_en = cfg.tr;
    assign resistor_array_en   = !cfg.tr;
    assign full_bridge_en      = cfg.tr && cfg.hbridge;

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_sync_q   <= 2'h0;
            htx_sync_q  <= 2'h0;
            hdir_sync_q <= 2'h0;
        end
        else
        begin
            rx_sync_q   <= {rx_sync_q[0], modem_rx_pin};
            htx_sync_q  <= {htx_sync_q[0], host_port_bit_one};
            hdir_sync_q <= {hdir_sync_q[0], host_port_bit_two};
        end
    end

    // Routing between modem, access controller and host pins
    assign modem_tx_data      = cfg.bypass ? htx_sync_q[1] : mac_tx_data;
    assign direction_select   = cfg.bypass ? hdir_sync_q[1] : mac_dir;
    assign host_port_bit_zero = cfg.bypass && cd_q;
    assign mac_carrier_detect = !cfg.bypass && cd_q;
    assign mac_rx_data        = !cfg.bypass && rx_sync_q[1];
    assign shared_host_input_line = cfg.bypass ? rx_sync_q[1] : mac_rx_irq;
    assign carrier_detect     = cd_q;

    // Checks
    cd_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy |=> carrier_detect)
        else $error("carrier detect missed a low level");
    cd_free_a: assert property (@(posedge pclk) disable iff (!presetn)
        !busy |=> !carrier_detect)
        else $error("carrier detect set at a high level");
    full_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.bypass |-> !host_port_bit_zero && modem_tx_data == mac_tx_data)
        else $error("modem signal reached host in full operation");
    shared_line_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.bypass |-> shared_host_input_line == mac_rx_irq)
        else $error("shared line not carrying receive interrupt");
    rx_dev_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.receive_deviation_bit |=> rx_space_hz - rx_mark_hz == $past(bd_hz))
        else $error("receive tone spacing wrong for deviation one");
    tx_dev_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.transmit_deviation_bit && modem_tx_data |=> $past(car_hz) - tx_tone_hz == ($past(bd_hz) >> 2))
        else $error("transmit mark tone wrong for deviation half");
    stage_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        transistor_stage_en != resistor_array_en)
        else $error("output stages not exclusive");
    ath_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        decide && !too_false && !too_missed |=> $stable(ath_q))
        else $error("auto threshold changed within limit");
    run_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(decide) |-> $past(tick_q) == tick_end - 1'b1)
        else $error("decision run off its period");
    err_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        do_rderr && !cfg.auto_mode && !false_det |=> false_cnt_q == 8'h00)
        else $error("false count not cleared after read");
    thr_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        do_write_threshold_bit |=> mth_q == $past(window_q))
        else $error("manual threshold not loaded");

    cov_decide_c: cover property (@(posedge pclk) disable iff (!presetn)
        decide && too_false);
    cov_bypass_c: cover property (@(posedge pclk) disable iff (!presetn)
        cfg.bypass && host_port_bit_zero);
    cov_rderr_c: cover property (@(posedge pclk) disable iff (!presetn)
        do_rderr && !cfg.auto_mode);
endmodule

/* flmc_mac_model.sv */
// Access controller stand-in driving full-operation traffic
`timescale 1ns/1ns
module flmc_mac_model (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      mac_tx_data,
    output logic      mac_dir,
    output logic      mac_rx_irq
);
    // Fresh bits every cycle, so a stuck route cannot hide
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {mac_tx_data, mac_dir, mac_rx_irq} <= 3'h0;
        else
            {mac_tx_data, mac_dir, mac_rx_irq} <= 3'($urandom);
endmodule

/* tb.sv */
// Self-checking bench for the line modem control block
`timescale 1ns/1ns
module tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = 0, txt, rmk, rsp;
    logic [31:0] pwdata = 0, prdata, r;
    logic [23:0] rx_level = 0, v;
    logic        fd = 0, md = 0, sd = 0, rxp = 0, hb1 = 0, hb2 = 0;
    logic        pready, pslverr, se, p, mtx, mdir, mirq, txd, dsel, mrx, mcd, hb0, shl, tse;
    logic        rae, cd, fbe;
    int          fail_count = 0, cmp_count = 0, thr, b, dt, dr, tr, hbr;
    int          car[8] = '{60000, 66000, 72000, 76000, 82050, 86000, 110000, 132500};
    int          bd[4] = '{600, 1200, 2400, 4800};
    logic [15:0] ix[6] = '{flmc_pkg::IDX_FREQ, flmc_pkg::IDX_CONFIG, flmc_pkg::IDX_MODE,
                           flmc_pkg::IDX_PERIOD, flmc_pkg::IDX_ERRLIM, flmc_pkg::IDX_BAUD};
    logic [7:0]  rv[6] = '{8'h07, 8'h06, 8'h01, 8'h20, 8'h0F, 8'h02};
    always #20 pclk = ~pclk;
    flmc_top #(.TICK_SHIFT(4)) flmc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rx_level, .peak_level(rx_level), .false_det(fd),
        .missed_det(md), .success_det(sd), .modem_rx_pin(rxp), .modem_tx_data(txd),
        .direction_select(dsel), .mac_tx_data(mtx), .mac_dir(mdir), .mac_rx_irq(mirq),
        .mac_rx_data(mrx), .mac_carrier_detect(mcd), .host_port_bit_one(hb1),
        .host_port_bit_two(hb2), .host_port_bit_zero(hb0), .shared_host_input_line(shl),
        .tx_tone_hz(txt), .rx_mark_hz(rmk), .rx_space_hz(rsp), .transistor_stage_en(tse),
        .resistor_array_en(rae), .full_bridge_en(fbe), .carrier_detect(cd));
    flmc_mac_model flmc_mac_model_i (.pclk, .presetn, .mac_tx_data(mtx), .mac_dir(mdir),
        .mac_rx_irq(mirq));
    function automatic int tone(int c, int bb, int h, logic m);
        return m ? c - bb / (h ? 4 : 2) : c + bb / (h ? 4 : 2);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {a, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        se = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // Strobe a control bit, then gather the three-byte window
    task automatic rd24(input logic [7:0] c);
        apb(1'h1, flmc_pkg::IDX_CTRL, c);
        for (int j = 0; j < 3; j++)
        begin
            apb(1'h0, 16'(flmc_pkg::IDX_TH2 + j), 8'h0);
            v[23 - 8 * j -: 8] = r[7:0];
        end
    endtask
    task automatic ev(input logic [2:0] e);
        {fd, md, sd} <= e;
        @(posedge pclk);
        {fd, md, sd} <= 3'h0;
        @(posedge pclk);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        complete_run();
    end
    initial
    begin
        void'($urandom(82));
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        foreach (ix[i])
        begin
            apb(1'h0, ix[i], 8'h0);
            chk("reset value", rv[i], r);
        end
        apb(1'h0, 16'h0000, 8'h0);
        chk("unmapped err", 1, se);
        for (int i = 0; i < 8; i++)
        begin
            b = (i == 7) ? 2 : $urandom % 4;
            dt = (b == 0) ? 0 : $urandom % 2;
            dr = (i == 7 && b == 2) ? dt & $urandom % 2 : 0;
            tr = $urandom % 2;
            hbr = $urandom % 2;
            apb(1'h1, flmc_pkg::IDX_FREQ, 8'(i));
            apb(1'h1, flmc_pkg::IDX_BAUD, 8'(b));
            // Bit 1 keeps its reset value: not ours to change
            apb(1'h1, flmc_pkg::IDX_CONFIG, 8'(dr * 64 + dt * 32 + hbr * 8 + tr * 4 + 2));
            @(negedge pclk);
            p = txd;
            chk("rx mark", tone(car[i], bd[b], dr, 1'h1), rmk);
            chk("rx space", tone(car[i], bd[b], dr, 1'h0), rsp);
            chk("transistor", tr, tse);
            chk("resistor", tr == 0, rae);
            chk("full bridge", tr & hbr, fbe);
            chk("tx route", mtx, txd);
            chk("dir route", mdir, dsel);
            chk("irq route", mirq, shl);
            chk("cd host off", 0, hb0);
            @(negedge pclk);
            chk("tx tone", tone(car[i], bd[b], dt, p), txt);
            @(posedge pclk);
        end
        apb(1'h1, flmc_pkg::IDX_MODE, 8'h0);
        for (int j = 0; j < 3; j++)
            apb(1'h1, 16'(flmc_pkg::IDX_TH2 + j), j == 1 ? 8'h10 : 8'h0);
        apb(1'h1, flmc_pkg::IDX_CTRL, 8'h02);
        rd24(8'h04);
        chk("manual thr", 24'h001000, v);
        for (int k = 1; k >= 0; k--)
        begin
            rx_level <= k ? 24'h001001 : 24'h000FFF;
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk("busy", k == 0, cd);
            chk("cd to mac", k == 0, mcd);
            @(posedge pclk);
        end
        for (int k = 0; k < 6; k++)
            ev(k < 3 ? 3'h4 : k < 4 ? 3'h2 : 3'h1);
        rd24(8'h10);
        chk("counts", 24'h030102, v);
        rd24(8'h10);
        chk("counts cleared", 0, v);
        rd24(8'h01);
        chk("peak", 24'h000FFF, v);
        apb(1'h1, flmc_pkg::IDX_BYPASS, 8'h01);
        {hb1, hb2, rxp} <= 3'($urandom);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk("tx bypass", hb1, txd);
        chk("dir bypass", hb2, dsel);
        chk("rx bypass", rxp, shl);
        chk("cd bypass", 1, hb0);
        chk("mac cd off", 0, mcd);
        chk("mac rx off", 0, mrx);
        @(posedge pclk);
        // Short period and zero limit: one event tips a run
        apb(1'h1, flmc_pkg::IDX_PERIOD, 8'h01);
        apb(1'h1, flmc_pkg::IDX_ERRLIM, 8'h00);
        apb(1'h1, flmc_pkg::IDX_MODE, 8'h01);
        thr = 24'h100000;
        for (int k = 0; k < 3; k++)
        begin
            ev(k == 1 ? 3'h4 : k == 2 ? 3'h2 : 3'h0);
            thr += k == 1 ? -256 : k == 2 ? 256 : 0;
            repeat (40) @(posedge pclk);
            rd24(8'h08);
            chk("auto thr", thr, v);
        end
        complete_run();
    end
endmodule
